// ===== rtl/pic_pkg.sv
package pic_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_SRC   = 18;
  localparam int FIRST_VEC = 4;

  // ----------------------------------------
  // Vector numbers
  // ----------------------------------------
  localparam logic [4:0] VEC_RESET    = 5'h00;
  localparam logic [4:0] VEC_MISALIGN = 5'h01;
  localparam logic [4:0] VEC_NMI      = 5'h02;
  localparam logic [4:0] VEC_RESERVED = 5'h03;
  localparam logic [4:0] VEC_SVD      = 5'h04;
  localparam logic [4:0] VEC_IR       = 5'h15;

  // ----------------------------------------
  // Table base and addresses
  // ----------------------------------------
  localparam logic [23:0] TABLE_BASE_RESET = 24'h008000;
  localparam logic [23:0] DEBUG_ADDR       = 24'hfffc00;
  localparam logic [7:0]  BASE_LOW_ZERO    = 8'h00;
  localparam int          VEC_SHIFT        = 2;

  // ----------------------------------------
  // Levels and fixed priorities
  // ----------------------------------------
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  localparam logic [2:0] LEVEL_NONE  = 3'h0;
  localparam logic [2:0] PRIO_RESET    = 3'h1;
  localparam logic [2:0] PRIO_MISALIGN = 3'h2;
  localparam logic [2:0] PRIO_DEBUG    = 3'h3;
  localparam logic [2:0] PRIO_NMI      = 3'h4;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        req;
    logic [2:0]  level;
    logic [4:0]  vector;
  } pic_req_type;

  typedef struct packed {
    logic        valid;
    logic [2:0]  prio;
    logic        debug;
    logic [4:0]  vector;
    logic [23:0] addr;
  } pic_nmi_type;

endpackage : pic_pkg

// ===== rtl/pic_unit.sv
`timescale 1ns/100ps
// Overview of operation
// - Peripheral requests are arbitrated and a request, level and vector go to the CPU.
// - Every maskable source has its own 3-bit level of eight values.
// - Among simultaneous requests the highest level wins.
// - Equal levels are broken in favour of the smaller vector number.
// - Handler address is table base plus four times the vector, base resets to 0x8000.
// - Vector 0 serves every reset cause at table offset 0x00.
// - Non-maskable events rank reset, misaligned, debug at 0xfffc00, watchdog NMI; 3 is reserved.
// - Vectors 4 to 8 are supply detector, port group 0, power, clock and real-time clock.
// - Vectors 9 to 16 are timer 0, serial 0, timer 1, sync serial 0, two-wire 0, PWM 0 to 2.
// - Vectors 17 to 21 are serial 1, timer 2, sync serial 1, sound and infrared remote.
// - Levels reset to zero and a level-zero request is never presented.
// - A newer higher-priority request replaces the presented one, which stays pending.
// - A request whose line drops before acceptance is discarded.
// - The low eight bits of the table base are always zero.
module pic_unit (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic [pic_pkg::NUM_SRC-1:0]    src_req,
  input  wire logic [pic_pkg::NUM_SRC*3-1:0]  src_level,
  input  wire logic                           level_we,
  input  wire logic [23:0]                    base_wdata,
  input  wire logic                           base_we,
  input  wire logic                           reset_event,
  input  wire logic                           misalign_event,
  input  wire logic                           debug_event,
  input  wire logic                           wdt_nmi_event,
  input  wire logic                           cpu_ack,
  output pic_pkg::pic_req_type                cpu_irq,
  output logic [23:0]                         cpu_vec_addr,
  output pic_pkg::pic_nmi_type                cpu_nmi,
  output logic [23:0]                         vector_table_base
);

  // ----------------------------------------
  // Level storage
  // ----------------------------------------
  logic [2:0] level [pic_pkg::NUM_SRC];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
        level[i] <= pic_pkg::LEVEL_RESET;
      end
    end else if (level_we) begin
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
        level[i] <= src_level[i*3 +: 3];
      end
    end
  end

  // ----------------------------------------
  // Table base
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vector_table_base <= pic_pkg::TABLE_BASE_RESET;
    end else if (base_we) begin
      vector_table_base <= {base_wdata[23:8], pic_pkg::BASE_LOW_ZERO};
    end
  end

  function automatic logic [23:0] pic_vec_addr(input logic [23:0] base, input logic [4:0] vec);
    pic_vec_addr = base + (24'(vec) << pic_pkg::VEC_SHIFT);
  endfunction : pic_vec_addr

  // ----------------------------------------
  // Maskable arbitration
  // ----------------------------------------
  // Source i carries vector FIRST_VEC+i, in order supply detector .. infrared remote
  logic       win_valid;
  logic [2:0] win_level;
  logic [4:0] win_vec;

  always_comb begin
    win_valid = 1'b0;
    win_level = pic_pkg::LEVEL_NONE;
    win_vec   = pic_pkg::VEC_SVD;
    for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
      // Strict greater keeps the smaller vector on equal levels
      if (src_req[i] && level[i] != pic_pkg::LEVEL_NONE &&
          (!win_valid || level[i] > win_level)) begin
        win_valid = 1'b1;
        win_level = level[i];
        win_vec   = 5'(pic_pkg::FIRST_VEC + i);
      end
    end
  end

  // ----------------------------------------
  // Presented request
  // ----------------------------------------
  // Two idle cycles after acknowledge so the source can drop its line
  logic ack_hold;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_hold <= 1'b0;
    end else begin
      ack_hold <= cpu_ack && cpu_irq.req;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_irq      <= '0;
      cpu_vec_addr <= pic_pkg::TABLE_BASE_RESET;
    end else begin
      cpu_irq.req    <= win_valid && !ack_hold && !(cpu_ack && cpu_irq.req);
      cpu_irq.level  <= win_level;
      cpu_irq.vector <= win_vec;
      cpu_vec_addr   <= pic_vec_addr(vector_table_base, win_vec);
    end
  end

  // ----------------------------------------
  // Non-maskable events
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_nmi.debug  <= 1'b0;
      cpu_nmi.valid  <= 1'b1;
      cpu_nmi.prio   <= pic_pkg::PRIO_RESET;
      cpu_nmi.vector <= pic_pkg::VEC_RESET;
      cpu_nmi.addr   <= pic_pkg::TABLE_BASE_RESET;
    end else begin
      cpu_nmi.valid <= reset_event || misalign_event || debug_event || wdt_nmi_event;
      cpu_nmi.debug <= 1'b0;
      if (reset_event) begin
        cpu_nmi.prio   <= pic_pkg::PRIO_RESET;
        cpu_nmi.vector <= pic_pkg::VEC_RESET;
        cpu_nmi.addr   <= pic_vec_addr(vector_table_base, pic_pkg::VEC_RESET);
      end else if (misalign_event) begin
        cpu_nmi.prio   <= pic_pkg::PRIO_MISALIGN;
        cpu_nmi.vector <= pic_pkg::VEC_MISALIGN;
        cpu_nmi.addr   <= pic_vec_addr(vector_table_base, pic_pkg::VEC_MISALIGN);
      end else if (debug_event) begin
        cpu_nmi.prio   <= pic_pkg::PRIO_DEBUG;
        cpu_nmi.debug  <= 1'b1;
        cpu_nmi.vector <= pic_pkg::VEC_RESERVED;
        cpu_nmi.addr   <= pic_pkg::DEBUG_ADDR;
      end else begin
        cpu_nmi.prio   <= pic_pkg::PRIO_NMI;
        cpu_nmi.vector <= pic_pkg::VEC_NMI;
        cpu_nmi.addr   <= pic_vec_addr(vector_table_base, pic_pkg::VEC_NMI);
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_level_nonzero: assert property (@(posedge clk) disable iff (!resetn)
    cpu_irq.req |-> cpu_irq.level != pic_pkg::LEVEL_NONE)
    else $error("Level zero request presented");

  a_request_follows: assert property (@(posedge clk) disable iff (!resetn)
    cpu_irq.req && !cpu_ack && win_valid |=> cpu_irq.req)
    else $error("Presented request withdrawn without acknowledge");

  a_highest_level: assert property (@(posedge clk) disable iff (!resetn)
    win_valid |=> cpu_irq.level == $past(win_level))
    else $error("Presented level is not the winner");

  a_vector_range: assert property (@(posedge clk) disable iff (!resetn)
    cpu_irq.req |-> cpu_irq.vector >= pic_pkg::VEC_SVD && cpu_irq.vector <= pic_pkg::VEC_IR)
    else $error("Maskable vector out of range");

  a_ack_drops: assert property (@(posedge clk) disable iff (!resetn)
    cpu_ack && cpu_irq.req |=> !cpu_irq.req ##1 !cpu_irq.req)
    else $error("Request not withdrawn after acknowledge");

  a_source_drop: assert property (@(posedge clk) disable iff (!resetn)
    src_req == '0 |=> !cpu_irq.req)
    else $error("Request held after sources dropped");

  a_addr_match: assert property (@(posedge clk) disable iff (!resetn)
    cpu_irq.req |-> cpu_vec_addr == $past(vector_table_base) + {cpu_irq.vector, 2'h0})
    else $error("Vector address mismatch");

  a_base_aligned: assert property (@(posedge clk) disable iff (!resetn)
    vector_table_base[7:0] == pic_pkg::BASE_LOW_ZERO)
    else $error("Table base not aligned");

  a_reset_first: assert property (@(posedge clk) disable iff (!resetn)
    reset_event |=> cpu_nmi.valid && cpu_nmi.prio == pic_pkg::PRIO_RESET)
    else $error("Reset not top non-maskable");

  a_idle_after_reset: assert property (@(posedge clk) disable iff (!resetn)
    !$past(resetn) |-> !cpu_irq.req)
    else $error("Request presented right after reset");

  a_base_reset: assert property (@(posedge clk) disable iff (!resetn)
    !$past(resetn) |-> vector_table_base == pic_pkg::TABLE_BASE_RESET)
    else $error("Table base wrong after reset");

  a_winner_nonzero: assert property (@(posedge clk) disable iff (!resetn)
    win_valid |-> win_level != pic_pkg::LEVEL_NONE)
    else $error("Level zero source won arbitration");

  a_newer_wins: assert property (@(posedge clk) disable iff (!resetn)
    win_valid && win_level > cpu_irq.level |=> cpu_irq.level > $past(cpu_irq.level))
    else $error("Higher request did not replace presented one");

  a_debug_fixed: assert property (@(posedge clk) disable iff (!resetn)
    cpu_nmi.debug |-> cpu_nmi.addr == pic_pkg::DEBUG_ADDR && cpu_nmi.prio == pic_pkg::PRIO_DEBUG)
    else $error("Debug entry not at fixed address");

  a_nmi_rank: assert property (@(posedge clk) disable iff (!resetn)
    misalign_event && !reset_event |=> cpu_nmi.prio == pic_pkg::PRIO_MISALIGN)
    else $error("Misaligned event not ranked second");

  a_nmi_addr: assert property (@(posedge clk) disable iff (!resetn)
    cpu_nmi.valid && !cpu_nmi.debug |->
      cpu_nmi.addr == $past(vector_table_base) + {cpu_nmi.vector, 2'h0})
    else $error("Non-maskable vector address mismatch");

  a_nmi_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !(reset_event || misalign_event || debug_event || wdt_nmi_event) |=> !cpu_nmi.valid)
    else $error("Non-maskable entry without event");

endmodule : pic_unit

// ===== sim/pic_cpu_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// CPU core stand-in
// ----------------------------------------
module pic_cpu_model (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire pic_pkg::pic_req_type irq,
  input  wire logic [2:0]           mask,
  output logic                      ack
);
  initial ack = 1'b0;
  always @(negedge clk) begin
    ack <= resetn && irq.req && (irq.level > mask) && !ack;
  end
endmodule : pic_cpu_model

// ===== sim/prioritised_interrupt_controller_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Bench
// ----------------------------------------
module prioritised_interrupt_controller_tb;
  logic                 clk        = 1'b0;
  logic                 resetn     = 1'b0;
  logic [17:0]          src_req    = '0;
  logic [53:0]          src_level  = '0;
  logic                 level_we   = 1'b0;
  logic                 base_we    = 1'b0;
  logic [23:0]          base_wdata = '0;
  logic [3:0]           ev         = '0;
  logic [2:0]           mask       = 3'h7;
  logic                 ack;
  pic_pkg::pic_req_type irq;
  pic_pkg::pic_nmi_type nmi;
  logic [23:0]          addr;
  logic [23:0]          base;
  int                   fail_count = 0;
  int                   n_tests    = 0;
  int                   cyc        = 0;

  always #4 clk = ~clk;

  pic_unit pic_unit_i (.clk(clk), .resetn(resetn), .src_req(src_req), .src_level(src_level),
    .level_we(level_we), .base_wdata(base_wdata), .base_we(base_we), .reset_event(ev[3]),
    .misalign_event(ev[2]), .debug_event(ev[1]), .wdt_nmi_event(ev[0]), .cpu_ack(ack),
    .cpu_irq(irq), .cpu_vec_addr(addr), .cpu_nmi(nmi), .vector_table_base(base));
  pic_cpu_model pic_cpu_model_i (.clk(clk), .resetn(resetn), .irq(irq), .mask(mask), .ack(ack));

  task tally_and_finish;
    $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task set_lv(input int i, input logic [2:0] v);
    src_level[3*i+:3] = v;
    level_we = 1'b1;
    step(1);
    level_we = 1'b0;
  endtask : set_lv

  task t_prio;
    src_req = 18'h3ffff;
    step(2);
    chk(irq.req, 1'b0);
    src_req = '0;
    set_lv(0, 3'h3);
    set_lv(5, 3'h6);
    set_lv(3, 3'h6);
    src_req = 18'h21;
    step(2);
    chk({irq.req, irq.level, irq.vector}, {1'b1, 3'h6, 5'h09});
    chk(addr, pic_pkg::TABLE_BASE_RESET + 24'h24);
    src_req[3] = 1'b1;
    step(1);
    chk(irq.vector, 5'h07);
    src_req[3] = 1'b0;
    step(1);
    chk(irq.vector, 5'h09);
    src_req[5] = 1'b0;
    step(1);
    chk({irq.level, irq.vector}, {3'h3, pic_pkg::VEC_SVD});
    src_req = '0;
    step(1);
    chk(irq.req, 1'b0);
  endtask : t_prio

  task t_base;
    base_wdata = 24'h1234ff;
    base_we = 1'b1;
    step(1);
    base_we = 1'b0;
    chk(base, 24'h123400);
    set_lv(17, 3'h1);
    src_req = 18'h20000;
    step(2);
    chk({irq.vector, addr}, {pic_pkg::VEC_IR, 24'h123454});
    src_req = '0;
  endtask : t_base

  task t_nmi;
    ev = 4'hf;
    for (int k = 0; k < 4; k++) begin
      step(1);
      chk({nmi.valid, nmi.prio}, {1'b1, 3'(k + 1)});
      if (k == 2) chk({nmi.debug, nmi.addr}, {1'b1, pic_pkg::DEBUG_ADDR});
      ev[3 - k] = 1'b0;
    end
    step(1);
    chk(nmi.valid, 1'b0);
  endtask : t_nmi

  task t_ack;
    set_lv(0, 3'h5);
    src_req = 18'h1;
    step(3);
    chk(ack, 1'b0);
    mask = 3'h4;
    for (int i = 0; i < 10 && ack !== 1'b1; i++) @(posedge clk);
    chk(ack, 1'b1);
    step(1);
    chk(irq.req, 1'b0);
    src_req = '0;
  endtask : t_ack

  initial begin
    step(8);
    chk({base, irq.req}, {pic_pkg::TABLE_BASE_RESET, 1'b0});
    chk({nmi.prio, nmi.vector}, {pic_pkg::PRIO_RESET, pic_pkg::VEC_RESET});
    resetn = 1'b1;
    step(1);
    t_prio();
    t_base();
    t_nmi();
    t_ack();
    tally_and_finish();
  end
endmodule : prioritised_interrupt_controller_tb
